// >>> prom_prog_pkg.sv
// constants and types for the fuse prom programmer
// assumes a 200 MHz core clock; pins are driven through external level shifters
package prom_prog_pkg;
    localparam int           CLK_MHZ          = 200;
    localparam int           ADDR_W           = 11;
    localparam int           DATA_W           = 4;
    // programming delay, us (least 10, most 100)
    localparam int           SETTLE_MIN_US    = 10;
    localparam int           SETTLE_MAX_US    = 100;
    // burn pulse width, us (least 100, most 1000)
    localparam int           PULSE_MIN_US     = 100;
    localparam int           PULSE_MAX_US     = 1000;
    // cumulative pulse time before reject, us
    localparam int           BURN_LIMIT_US    = 1000;
    localparam int           SETTLE_CYC       = SETTLE_MIN_US * CLK_MHZ;
    localparam int           PULSE_CYC        = PULSE_MIN_US * CLK_MHZ;
    localparam int           LIMIT_CYC        = BURN_LIMIT_US * CLK_MHZ;
    localparam int           CNT_W            = 20;
    localparam int           BURN_W           = 12;
    localparam logic [DATA_W-1:0] ERASED_WORD = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_RAISE  = 3'b010,
        ST_PULSE  = 3'b011,
        ST_GAP    = 3'b100,
        ST_LOWER  = 3'b101,
        ST_VERIFY = 3'b110,
        ST_DONE   = 3'b111
    } prog_state_t;
endpackage

// >>> pulse_timer_if.sv
// carries the load and expiry of the shared delay timer
// one sequencer drives it, one timer answers
`timescale 1ns/1ps
interface pulse_timer_if;
    logic                   load;
    logic [19:0]            count;
    logic                   expired;
    modport ctrl  (output load, output count, input expired);
    modport timer (input load, input count, output expired);
endinterface

// >>> delay_timer.sv
// down counter timing settle gaps and burn pulses
// load takes priority; expired holds high once the count reaches zero
`timescale 1ns/1ps
module delay_timer
    import prom_prog_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    pulse_timer_if.timer    tmr
);
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        if (tmr.load)
            cnt_nxt = tmr.count;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 20'h00001;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    // taken from the count alone: gating by load would loop back through the sequencer
    assign tmr.expired = (cnt_r == '0);
endmodule // delay_timer

// >>> prom_programmer.sv
// host-side sequencer that burns and verifies one 4-bit word of a fuse prom
// assumes external switches turn supply_high_o and burn_en_o into programming voltages
`timescale 1ns/1ps
module prom_programmer
    import prom_prog_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              start_i,
    input  wire logic [ADDR_W-1:0] word_addr_i,
    input  wire logic [DATA_W-1:0] burn_mask_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic [DATA_W-1:0]      reject_o,
    output logic [DATA_W-1:0]      read_word_o,
    output logic [ADDR_W-1:0]      prom_addr_o,
    output logic                   prom_cs_o,
    output logic                   supply_high_o,
    input  wire logic [DATA_W-1:0] prom_data_i,
    output logic [DATA_W-1:0]      burn_en_o,
    output logic [DATA_W-1:0]      burn_oe_o
);
    pulse_timer_if tmr ();

    delay_timer u_timer (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .tmr        (tmr)
    );

    prog_state_t                   state_r, state_nxt;
    logic [ADDR_W-1:0]             addr_r, addr_nxt;
    logic [DATA_W-1:0]             pend_r, pend_nxt;
    logic [DATA_W-1:0]             todo_r, todo_nxt;
    logic [DATA_W-1:0]             rej_r, rej_nxt;
    logic [DATA_W-1:0]             rd_r, rd_nxt;
    logic [1:0]                    bit_r, bit_nxt;
    logic                          done_r, done_nxt;
    logic [BURN_W-1:0]             burn_us_r [DATA_W];
    logic [BURN_W-1:0]             burn_us_nxt [DATA_W];
    logic [DATA_W-1:0]             exhausted;
    logic [DATA_W-1:0]             first_sel;
    logic [1:0]                    first_idx;

    // a bit is out of budget when another pulse would not fit under the limit
    generate
        for (genvar g = 0; g < DATA_W; g++)
        begin : g_budget
            assign exhausted[g] =
                (32'(burn_us_r[g]) + 32'(PULSE_MIN_US)) > 32'(BURN_LIMIT_US);
        end
    endgenerate

    // lowest pending bit is burned next; one at a time
    always_comb
    begin
        first_sel = '0;
        first_idx = 2'h0;
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
            if (todo_r[i])
            begin
                first_sel = '0;
                first_sel[i] = 1'b1;
                first_idx = 2'(i);
            end
        end
    end

    always_comb
    begin
        state_nxt   = state_r;
        addr_nxt    = addr_r;
        pend_nxt    = pend_r;
        todo_nxt    = todo_r;
        rej_nxt     = rej_r;
        rd_nxt      = rd_r;
        bit_nxt     = bit_r;
        done_nxt    = 1'b0;
        burn_us_nxt = burn_us_r;
        tmr.load    = 1'b0;
        tmr.count   = 20'(SETTLE_CYC);
        case (state_r)
            ST_IDLE:
            begin
                if (start_i)
                begin
                    addr_nxt = word_addr_i;
                    pend_nxt = burn_mask_i;
                    rej_nxt  = '0;
                    for (int i = 0; i < DATA_W; i++)
                        burn_us_nxt[i] = '0;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // only bits still pending and within budget get another pulse
                todo_nxt = pend_r & ~exhausted;
                rej_nxt  = rej_r | (pend_r & exhausted);
                if ((pend_r & ~exhausted) == '0)
                    state_nxt = ST_DONE;
                else
                begin
                    tmr.load  = 1'b1;
                    tmr.count = 20'(SETTLE_CYC);
                    state_nxt = ST_RAISE;
                end
            end
            ST_RAISE, ST_GAP:
            begin
                if (tmr.expired)
                begin
                    tmr.load = 1'b1;
                    if (todo_r == '0)
                    begin
                        tmr.count = 20'(SETTLE_CYC);
                        state_nxt = ST_LOWER;
                    end
                    else
                    begin
                        tmr.count = 20'(PULSE_CYC);
                        bit_nxt   = first_idx;
                        state_nxt = ST_PULSE;
                    end
                end
            end
            ST_PULSE:
            begin
                if (tmr.expired)
                begin
                    todo_nxt = todo_r & ~first_sel;
                    burn_us_nxt[bit_r] = burn_us_r[bit_r] + BURN_W'(PULSE_MIN_US);
                    tmr.load  = 1'b1;
                    tmr.count = 20'(SETTLE_CYC);
                    state_nxt = ST_GAP;
                end
            end
            ST_LOWER:
            begin
                // supply at verify level; give the device a settle before sampling
                if (tmr.expired)
                    state_nxt = ST_VERIFY;
            end
            ST_VERIFY:
            begin
                rd_nxt    = prom_data_i;
                // a burned fuse reads low; clear those from the pending set
                pend_nxt  = pend_r & prom_data_i;
                state_nxt = ST_SETUP;
            end
            ST_DONE:
            begin
                done_nxt  = 1'b1;
                state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_r <= ST_IDLE;
            addr_r  <= '0;
            pend_r  <= '0;
            todo_r  <= '0;
            rej_r   <= '0;
            rd_r    <= ERASED_WORD;
            bit_r   <= 2'h0;
            done_r  <= 1'b0;
            for (int i = 0; i < DATA_W; i++)
                burn_us_r[i] <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            addr_r    <= addr_nxt;
            pend_r    <= pend_nxt;
            todo_r    <= todo_nxt;
            rej_r     <= rej_nxt;
            rd_r      <= rd_nxt;
            bit_r     <= bit_nxt;
            done_r    <= done_nxt;
            burn_us_r <= burn_us_nxt;
        end
    end

    assign busy_o        = (state_r != ST_IDLE);
    assign done_o        = done_r;
    assign reject_o      = rej_r;
    assign read_word_o   = rd_r;
    assign prom_addr_o   = addr_r;
    // deselected in every phase except the verify read
    assign prom_cs_o     = !(state_r == ST_VERIFY);
    assign supply_high_o = (state_r == ST_RAISE) || (state_r == ST_PULSE)
                        || (state_r == ST_GAP);
    // only the one pulsed output is driven, others float
    assign burn_en_o     = (state_r == ST_PULSE) ? (DATA_W'(1) << bit_r) : '0;
    assign burn_oe_o     = burn_en_o;
endmodule // prom_programmer

// >>> prom_fuse_model.sv
// behavioural 2048 x 4 fuse prom; bits in HARD_BITS need a second burn pulse
// assumes the programmer's pins arrive directly, sampled on the core clock
`timescale 1ns/1ps
module prom_fuse_model
    import prom_prog_pkg::*;
#(parameter logic [DATA_W-1:0] HARD_BITS = 4'h4)
(
    input  wire logic              core_clk_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              cs_i,
    input  wire logic [DATA_W-1:0] burn_i,
    output logic [DATA_W-1:0]      data_o
);
    logic [DATA_W-1:0] fuse_r [0:2047];
    logic [DATA_W-1:0] last_r = ERASED_WORD;
    logic [DATA_W-1:0] burn_r = '0;
    logic [3:0]        hits_r [DATA_W] = '{default: '0};
    int                width_r = 0;
    initial foreach (fuse_r[i]) fuse_r[i] = ERASED_WORD;
    // deselected pins float: show the inverse of the last word read
    assign data_o = cs_i ? ~last_r : fuse_r[addr_i];
    always @(posedge core_clk_i)
    begin
        if (!cs_i) last_r <= fuse_r[addr_i];
        if (burn_i != '0) burn_r <= burn_i;
        width_r <= (burn_i != '0) ? width_r + 1 : 0;
        // a pulse below the minimum width leaves the fuse intact
        if (burn_i == '0 && width_r >= PULSE_CYC)
            for (int b = 0; b < DATA_W; b++)
                if (burn_r[b])
                begin
                    hits_r[b] <= hits_r[b] + 4'h1;
                    if (hits_r[b] >= HARD_BITS[b]) fuse_r[addr_i][b] <= 1'h0;
                end
    end
endmodule // prom_fuse_model

// >>> prom_programmer_properties.sv
// pin checks on the prom programmer: burn pulses, settle gaps, verify slot
// bound into prom_programmer below; one clock domain
`timescale 1ns/1ps
module prom_programmer_properties
    import prom_prog_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rstn_i,
    input wire logic              prom_cs_o,
    input wire logic              supply_high_o,
    input wire logic [DATA_W-1:0] burn_en_o,
    input wire logic [DATA_W-1:0] burn_oe_o
);
    localparam int    MAX_CYC = PULSE_MAX_US * CLK_MHZ;
    logic [CNT_W-1:0] quiet_r, quiet_nxt, width_r, width_nxt;
    always_comb
    begin
        quiet_nxt = (supply_high_o && burn_en_o == '0) ? quiet_r + 1'h1 : '0;
        width_nxt = (burn_en_o != '0) ? width_r + 1'h1 : '0;
    end
    always_ff @(posedge core_clk_i or negedge rstn_i)
        if (!rstn_i) {quiet_r, width_r} <= '0;
        else {quiet_r, width_r} <= {quiet_nxt, width_nxt};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence verify_slot;
        !prom_cs_o ##1 prom_cs_o;
    endsequence
    one_burn_a: assert property ($onehot0(burn_en_o)) else $error("burn overlap");
    oe_match_a: assert property (burn_oe_o == burn_en_o) else $error("stray drive");
    burn_deselect_a: assert property (burn_en_o != '0 |-> prom_cs_o && supply_high_o)
        else $error("burn while selected");
    verify_level_a: assert property (!prom_cs_o |-> !supply_high_o) else $error("high verify");
    verify_slot_a: assert property ($fell(prom_cs_o) |-> verify_slot) else $error("long select");
    settle_gap_a: assert property (burn_en_o != '0 && $changed(burn_en_o) |-> quiet_r >= SETTLE_CYC)
        else $error("pulse too early");
    pulse_width_a: assert property ($fell(|burn_en_o) |-> width_r inside {[PULSE_CYC:MAX_CYC]})
        else $error("pulse width");
    lower_settle_a: assert property ($fell(supply_high_o) |-> quiet_r >= SETTLE_CYC)
        else $error("supply dropped early");
endmodule // prom_programmer_properties
bind prom_programmer prom_programmer_properties u_prom_programmer_properties (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .prom_cs_o(prom_cs_o),
    .supply_high_o(supply_high_o), .burn_en_o(burn_en_o), .burn_oe_o(burn_oe_o));

// >>> prom_programmer_tb.sv
// self-checking bench: prom programmer burning a behavioural fuse prom
// assumes the property checker is bound from its own file
`timescale 1ns/1ps
module prom_programmer_tb;
    import prom_prog_pkg::*;
    logic              core_clk_i = 1'h0;
    logic              rstn_i = 1'h0;
    logic              start_i = 1'h0;
    logic [ADDR_W-1:0] word_addr_i = '0;
    logic [DATA_W-1:0] burn_mask_i = '0;
    logic              busy_o, done_o, prom_cs_o, supply_high_o;
    logic [DATA_W-1:0] reject_o, read_word_o, prom_data_i, burn_en_o, burn_oe_o;
    logic [ADDR_W-1:0] prom_addr_o;
    int                fails = 0;
    int                checks_done = 0;
    prom_programmer u_prom_programmer (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .start_i(start_i), .word_addr_i(word_addr_i), .burn_mask_i(burn_mask_i),
        .busy_o(busy_o), .done_o(done_o), .reject_o(reject_o), .read_word_o(read_word_o),
        .prom_addr_o(prom_addr_o), .prom_cs_o(prom_cs_o), .supply_high_o(supply_high_o),
        .prom_data_i(prom_data_i), .burn_en_o(burn_en_o), .burn_oe_o(burn_oe_o));
    prom_fuse_model u_prom_fuse_model (.core_clk_i(core_clk_i), .addr_i(prom_addr_o),
        .cs_i(prom_cs_o), .burn_i(burn_en_o), .data_o(prom_data_i));
    task automatic check_val(string name, logic [ADDR_W-1:0] exp, logic [ADDR_W-1:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // start stays up a second cycle with a new address: busy must refuse it
    task automatic run_word(logic [ADDR_W-1:0] addr, logic [DATA_W-1:0] mask, int limit);
        int n;
        n = 0;
        word_addr_i = addr;
        burn_mask_i = mask;
        start_i = 1'h1;
        @(negedge core_clk_i);
        check_val("busy", 1'h1, busy_o);
        check_val("address", addr, prom_addr_o);
        word_addr_i = '0;
        @(negedge core_clk_i);
        check_val("held address", addr, prom_addr_o);
        start_i = 1'h0;
        while (done_o !== 1'h1 && n < limit)
        begin
            @(negedge core_clk_i);
            n++;
        end
        check_val("done", 1'h1, done_o);
    endtask
    task automatic test_two_bits();
        run_word(11'h400, 4'h5, 90000);
        check_val("reject", '0, reject_o);
        check_val("verify", 4'ha, read_word_o);
        check_val("top word", 4'ha, u_prom_fuse_model.fuse_r[11'h400]);
        check_val("word zero", 4'hf, u_prom_fuse_model.fuse_r[11'h000]);
        check_val("retries", 4'h2, u_prom_fuse_model.hits_r[2]);
    endtask
    task automatic test_empty_mask();
        run_word(11'h7ff, 4'h0, 8);
        check_val("reject", '0, reject_o);
        check_val("unburnt", 4'hf, u_prom_fuse_model.fuse_r[11'h7ff]);
    endtask
    initial forever #2.5 core_clk_i = ~core_clk_i;
    initial
    begin
        repeat (4) @(negedge core_clk_i);
        check_val("idle select", 1'h1, prom_cs_o);
        check_val("idle supply", 1'h0, supply_high_o);
        rstn_i = 1'h1;
        test_two_bits();
        test_empty_mask();
        give_verdict();
    end
    initial
    begin
        #(95000 * 5);
        fails++;
        give_verdict();
    end
endmodule // prom_programmer_tb
